/* File: testbench/cff_fifo_port_monitor.sv */
// Purpose: Concurrent checks on the FIFO port pins and the APB side.
// Assumes: Pin events reach the design through two-flop synchronisers.
// Notes: Ages count pclk cycles since a pin event and saturate at 15.
`default_nettype none
module cff_fifo_port_monitor import cff_pkg::*; (
    input wire logic pclk, // Clock.
    input wire logic presetn, // Reset.
    input wire logic psel, // Select.
    input wire logic penable, // Access phase.
    input wire logic [7:0] paddr, // Address.
    input wire logic [31:0] prdata, // Read data.
    input wire logic pready, // Ready.
    input wire logic pslverr, // Error.
    input wire logic write_clock, // Write clock pin.
    input wire logic read_clock, // Read clock pin.
    input wire logic read_enable_n, // Read enable pin.
    input wire logic [7:0] read_data_out, // Data out.
    input wire logic ninth_output_bit, // Ninth bit.
    input wire logic read_data_oe_n, // Drive enable.
    input wire logic output_enable_n, // Output enable pin.
    input wire logic half_full_flag, // Half flag.
    input wire logic empty_full_flag_n, // Empty or full flag.
    input wire logic master_reset_n // Master reset pin.
);
    logic [3:0] w_age_q, r_age_q, m_age_q;
    logic mapped;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign mapped = paddr inside {ADDR_CTRL, ADDR_STATUS, ADDR_PROG};
    // Ages tie each output change to the pin event that may cause it; the sync delay needs some slack.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            w_age_q <= 4'hF;
            r_age_q <= 4'hF;
            m_age_q <= 4'hF;
        end else begin
            w_age_q <= $rose(write_clock) ? 4'h0 : w_age_q + 4'(w_age_q != 4'hF);
            r_age_q <= ($rose(read_clock) && !read_enable_n) ? 4'h0 : r_age_q + 4'(r_age_q != 4'hF);
            m_age_q <= !master_reset_n ? 4'h0 : m_age_q + 4'(m_age_q != 4'hF);
        end
    end
    property p_ready; psel && penable |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low in access phase");
    property p_err_map; psel && penable && !mapped |-> pslverr; endproperty
    a_err_map: assert property (p_err_map) else $error("no error on unmapped address");
    property p_err_only; pslverr |-> psel && penable && !mapped; endproperty
    a_err_only: assert property (p_err_only) else $error("error outside unmapped access");
    property p_rdata_setup; $changed(prdata) |-> $past(psel) && !$past(penable); endproperty
    a_rdata_setup: assert property (p_rdata_setup) else $error("read data moved outside setup");
    property p_oe; $changed(output_enable_n) |-> ##[1:4] (read_data_oe_n == output_enable_n); endproperty
    a_oe: assert property (p_oe) else $error("drive enable not following pin");
    property p_half; $changed(half_full_flag) |-> w_age_q <= 4'h6 || m_age_q <= 4'h6; endproperty
    a_half: assert property (p_half) else $error("half flag moved without write edge");
    property p_ef; $changed(empty_full_flag_n) |-> w_age_q <= 4'h6 || r_age_q <= 4'h6 || m_age_q <= 4'h6; endproperty
    a_ef: assert property (p_ef) else $error("empty or full moved without clock edge");
    property p_q; $changed({ninth_output_bit, read_data_out}) |-> r_age_q <= 4'h6 || m_age_q <= 4'h6; endproperty
    a_q: assert property (p_q) else $error("outputs moved without enabled read");
    property p_mr; $fell(master_reset_n) |-> ##[2:6] (!empty_full_flag_n && half_full_flag); endproperty
    a_mr: assert property (p_mr) else $error("master reset did not empty buffer");
endmodule : cff_fifo_port_monitor
bind cff_fifo_port cff_fifo_port_monitor u_mon (.pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready,
    .pslverr, .write_clock, .read_clock, .read_enable_n, .read_data_out, .ninth_output_bit, .read_data_oe_n,
    .output_enable_n, .half_full_flag, .empty_full_flag_n, .master_reset_n);
`default_nettype wire

/* File: testbench/cff_fifo_port_tb.sv */
// Purpose: Self-checking bench for the clocked FIFO port.
// Assumes: Standalone use; pin traffic comes from the pin model.
// Notes: Read-side flags go stale during a fill, so only write-side flags are followed then.
`default_nettype none
module cff_fifo_port_tb import cff_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, output_enable_n, master_reset_n, pready, pslverr;
    logic write_clock, write_enable_n, read_clock, read_enable_n, ninth_output_bit, read_data_oe_n;
    logic half_full_flag, empty_full_flag_n, almost_flag_or_cascade_out, cascade_in, first_load_or_replay;
    logic [7:0] paddr, read_data_out;
    logic [31:0] pwdata, prdata, d;
    logic [DW-1:0] write_data_in, q;
    logic e;
    wire [DW-1:0] q_pins;
    int mismatches, checked;
    assign q_pins = read_data_oe_n ? {DW{1'bz}} : {ninth_output_bit, read_data_out};
    cff_fifo_port dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .write_clock, .write_enable_n, .write_data_in, .read_clock, .read_enable_n, .read_data_out,
        .ninth_output_bit, .read_data_oe_n, .output_enable_n, .half_full_flag, .empty_full_flag_n,
        .almost_flag_or_cascade_out, .cascade_in, .first_load_or_replay, .master_reset_n);
    cff_pin_model u_pins (.pclk, .q_pins, .write_clock, .write_enable_n, .write_data_in, .read_clock,
        .read_enable_n, .cascade_in, .first_load_or_replay);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp, input logic err);
        apb(1'b0, a, 32'h0);
        check(d & mask, exp);
        check(32'(e), 32'(err));
    endtask : reg_rd
    // With load set, a value is written and read back while master reset is held.
    task automatic mr(input logic load, input logic [DW-1:0] p);
        @(posedge pclk);
        master_reset_n <= 1'b0;
        repeat (8) @(posedge pclk);
        if (load) begin
            u_pins.put(1'b0, p);
            u_pins.take(1'b0, q);
            check(32'(q), 32'(p));
        end
        master_reset_n <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask : mr
    task automatic wrap_up();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        repeat (60000) @(posedge pclk);
        mismatches++;
        $display("MISMATCH at %0t: run did not finish", $time);
        wrap_up();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {output_enable_n, master_reset_n} = 2'b01;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, ADDR_CTRL, 32'h1);
        reg_rd(ADDR_CTRL, 32'hFFFFFFFF, 32'h1, 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h0);
        reg_rd(8'h0C, 32'hFFFFFFFF, 32'h0, 1'b1);
        mr(1'b0, 9'h000);
        reg_rd(ADDR_PROG, 32'hFFFFFFFF, 32'h010, 1'b0);
        reg_rd(ADDR_STATUS, 32'h3FF1F, 32'h3, 1'b0);
        for (int i = 0; i < 512; i++) begin
            u_pins.put(1'b0, 9'(i));
            check(32'(half_full_flag), (i >= 256) ? 32'h0 : 32'h1);
        end
        check(32'({empty_full_flag_n, almost_flag_or_cascade_out}), 32'h0);
        u_pins.put(1'b0, 9'h1AA);
        reg_rd(ADDR_STATUS, 32'h3FF1C, 32'h2001C, 1'b0);
        for (int i = 0; i < 512; i++) begin
            u_pins.take(1'b0, q);
            check(32'(q), 32'(i));
            // Empty has just cleared, so only the stale full and almost-full flags can hold the pins low.
            if (i == 0) begin
                check(32'({empty_full_flag_n, almost_flag_or_cascade_out}), 32'h0);
            end
        end
        u_pins.take(1'b0, q);
        check(32'(q), 32'h1FF);
        u_pins.put(1'b0, 9'h055);
        u_pins.put(1'b1, 9'h0AA);
        u_pins.take(1'b0, q);
        u_pins.take(1'b0, q);
        check(32'(q), 32'h055);
        mr(1'b1, 9'h105);
        reg_rd(ADDR_PROG, 32'hFFFFFFFF, 32'h105, 1'b0);
        u_pins.put(1'b0, 9'h103);
        u_pins.put(1'b0, 9'h007);
        u_pins.take(1'b0, q);
        check(32'(q), 32'h003);
        u_pins.take(1'b0, q);
        check(32'(q), 32'h107);
        mr(1'b1, 9'h185);
        u_pins.put(1'b0, 9'h101);
        u_pins.put(1'b0, 9'h001);
        u_pins.take(1'b0, q);
        check(32'(q), 32'h001);
        u_pins.take(1'b0, q);
        check(32'(q), 32'h101);
        // Cascaded without the head select, the device holds no token and must refuse writes.
        apb(1'b1, ADDR_CTRL, 32'h1);
        mr(1'b0, 9'h000);
        u_pins.put(1'b0, 9'h033);
        check(32'(almost_flag_or_cascade_out), 32'h1);
        reg_rd(ADDR_STATUS, 32'h3FF60, 32'h0, 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h0);
        mr(1'b0, 9'h000);
        u_pins.put(1'b0, 9'h011);
        u_pins.put(1'b0, 9'h022);
        u_pins.take(1'b0, q);
        check(32'({empty_full_flag_n, almost_flag_or_cascade_out}), 32'h2);
        u_pins.take(1'b0, q);
        u_pins.replay();
        u_pins.take(1'b0, q);
        check(32'(q), 32'h011);
        output_enable_n <= 1'b1;
        repeat (6) @(posedge pclk);
        check(32'(read_data_oe_n), 32'h1);
        output_enable_n <= 1'b0;
        repeat (6) @(posedge pclk);
        wrap_up();
    end
endmodule : cff_fifo_port_tb
`default_nettype wire

/* File: testbench/cff_pin_model.sv */
// Purpose: Producer and consumer logic on the FIFO pins.
// Assumes: Pin clocks stand still between transfers.
// Notes: Edges are at least four pclk apart so setup, hold and pulse width beat the synchronisers.
`default_nettype none
module cff_pin_model import cff_pkg::*; (
    input wire logic pclk, // Pacing clock.
    input wire logic [DW-1:0] q_pins, // Resolved output pins.
    output logic write_clock, // Write clock.
    output logic write_enable_n, // Write enable.
    output logic [DW-1:0] write_data_in, // Write data.
    output logic read_clock, // Read clock.
    output logic read_enable_n, // Read enable.
    output logic cascade_in, // Expansion in.
    output logic first_load_or_replay // Head select or replay.
);
    // Standalone wiring: expansion in low, head select high.
    initial begin
        write_clock = 1'b0;
        write_enable_n = 1'b1;
        write_data_in = 9'h000;
        read_clock = 1'b0;
        read_enable_n = 1'b1;
        cascade_in = 1'b0;
        first_load_or_replay = 1'b1;
    end
    task automatic put(input logic en_n, input logic [DW-1:0] d);
        @(posedge pclk);
        write_enable_n <= en_n;
        write_data_in <= d;
        repeat (4) @(posedge pclk);
        write_clock <= 1'b1;
        repeat (4) @(posedge pclk);
        write_clock <= 1'b0;
        write_enable_n <= 1'b1;
        write_data_in <= ~d; // Released data never shows the old word.
        repeat (4) @(posedge pclk);
    endtask : put
    task automatic take(input logic en_n, output logic [DW-1:0] q);
        @(posedge pclk);
        read_enable_n <= en_n;
        repeat (4) @(posedge pclk);
        read_clock <= 1'b1;
        repeat (5) @(posedge pclk);
        q = q_pins;
        read_clock <= 1'b0;
        read_enable_n <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask : take
    // Both enables are already high here, as a replay needs.
    task automatic replay();
        @(posedge pclk);
        first_load_or_replay <= 1'b0;
        repeat (4) @(posedge pclk);
        first_load_or_replay <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask : replay
endmodule : cff_pin_model
`default_nettype wire

/* File: verilog/cff_fifo_port.sv */
// Purpose: Nine-bit clocked FIFO with programming register, parity, flags, cascade and replay.
// Assumes: Write and read clocks are pins far slower than pclk; every pin passes two flip-flops.
// Notes: Flags are active low on pins; APB holds the cascade control and a status view.
// Behaviour
// - Enabled write-clock rising edge stores the input word at the next free slot.
// - Writes are dropped while the buffer is full.
// - Enabled read-clock rising edge outputs the oldest word and advances.
// - Reads while empty do not advance the read position.
// - During master reset an enabled write edge loads the programming register.
// - During master reset an enabled read edge outputs the programming register.
// - In generation mode the ninth input bit is ignored and parity computed.
// - Ninth output bit is data, generated parity, or parity error by mode.
// - Enables gate both clocks alike in normal and programming mode.
// - Half-full, almost-full and full change only on write-clock edges and master reset.
// - Empty and almost-empty change only on read-clock edges and master reset.
// - One pin shows empty on the read side and full on the write side.
// - Dual pin shows almost flags standalone, expansion signal when cascaded.
// - Standalone, a low strobe on first-load/replay restarts reading from the start.
// - Master reset empties the buffer.
// - Master reset restores defaults: parity off, almost threshold sixteen.
// - Standalone, three status outputs encode six fill states.
`default_nettype none
module cff_fifo_port (
    input wire logic pclk,                                // System clock.
    input wire logic presetn,                             // Async reset, active low.
    input wire logic psel,                                // APB select.
    input wire logic penable,                             // APB access phase.
    input wire logic pwrite,                              // APB direction.
    input wire logic [7:0] paddr,                         // APB byte address.
    input wire logic [31:0] pwdata,                       // APB write data.
    output logic [31:0] prdata,                           // APB read data.
    output logic pready,                                  // APB ready.
    output logic pslverr,                                 // APB error on unmapped address.
    input wire logic write_clock,                         // Write clock pin.
    input wire logic write_enable_n,                      // Write enable, active low.
    input wire logic [cff_pkg::DW-1:0] write_data_in,     // Write data pins.
    input wire logic read_clock,                          // Read clock pin.
    input wire logic read_enable_n,                       // Read enable, active low.
    output logic [7:0] read_data_out,                     // Read data pins.
    output logic ninth_output_bit,                        // Data, parity or parity error.
    output logic read_data_oe_n,                          // Drive enable for all nine outputs, low drives.
    input wire logic output_enable_n,                     // Output enable pin, active low.
    output logic half_full_flag,                          // Half full, active low.
    output logic empty_full_flag_n,                       // Empty or full, active low.
    output logic almost_flag_or_cascade_out,              // Almost flag or expansion out, active low.
    input wire logic cascade_in,                          // Expansion in, active low pulse.
    input wire logic first_load_or_replay,                // Chain head select or replay strobe.
    input wire logic master_reset_n                       // Master reset pin, active low.
);
    import cff_pkg::*;

    logic [SW-1:0] s1_q, s2_q, s3_q;
    logic [DW-1:0] mem [0:DEPTH-1];
    logic [PW-1:0] wptr_q, rptr_q, wptr_d, rptr_d, cnt_d;
    logic [DW-1:0] prog_q, rdata_q, wword;
    logic ctrl_cascade_q, wtok_q, rtok_q, xo_n_q;
    logic empty_q, aempty_q, half_q, afull_q, full_q;
    logic [31:0] prdata_q;
    logic wedge, redge, mr_act, mr_fall, mr_rise, rt_fall, cin_fall;
    logic do_wr, do_rd, rt_go, full_now, empty_now, casc;
    logic [PRG_THR_W-1:0] thr;

    // Every pin passes two flops; the third stage only feeds edge detectors.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= SYNC_RST;
            s2_q <= SYNC_RST;
            s3_q <= SYNC_RST;
        end else begin
            s1_q <= {write_clock, read_clock, write_enable_n, read_enable_n, master_reset_n,
                     first_load_or_replay, cascade_in, output_enable_n, write_data_in};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Edges are seen in the pclk the second flop changes, with data sampled through the same depth.
    assign wedge = s2_q[S_WCLK] & ~s3_q[S_WCLK];
    assign redge = s2_q[S_RCLK] & ~s3_q[S_RCLK];
    assign mr_act = ~s2_q[S_MR];
    assign mr_fall = ~s2_q[S_MR] & s3_q[S_MR];
    assign mr_rise = s2_q[S_MR] & ~s3_q[S_MR];
    assign rt_fall = ~s2_q[S_FL] & s3_q[S_FL];
    assign cin_fall = ~s2_q[S_CIN] & s3_q[S_CIN];
    assign casc = ctrl_cascade_q;
    assign thr = prog_q[PRG_THR_W-1:0];
    assign full_now = (wptr_q - rptr_q) == DEPTH;
    assign empty_now = wptr_q == rptr_q;

    // Enables gate the clocks; a clock edge without its enable moves no data but still refreshes its own side's flags.
    assign do_wr = wedge & ~s2_q[S_WEN] & ~mr_act & ~full_now & (~casc | wtok_q);
    assign do_rd = redge & ~s2_q[S_REN] & ~mr_act & ~empty_now & (~casc | rtok_q);
    // Replay relies on both enables being high; it is ignored while cascaded.
    assign rt_go = rt_fall & ~casc & ~mr_act & s2_q[S_WEN] & s2_q[S_REN];

    // Generated parity is even over the low eight bits and replaces the ninth input bit.
    always_comb begin
        wword = s2_q[DW-1:0];
        if (prog_q[PRG_PAR_EN] && !prog_q[PRG_CHECK]) begin
            wword[8] = ^s2_q[7:0];
        end
    end

    // Next pointers, used so that each domain's flags see the result of its own edge.
    always_comb begin
        wptr_d = wptr_q;
        rptr_d = rptr_q;
        if (mr_act) begin
            wptr_d = '0;
            rptr_d = '0;
        end else begin
            if (do_wr) begin
                wptr_d = wptr_q + 10'h001;
            end
            if (rt_go) begin
                rptr_d = '0;
            end else if (do_rd) begin
                rptr_d = rptr_q + 10'h001;
            end
        end
        cnt_d = wptr_d - rptr_d;
    end

    // Memory write port.
    always_ff @(posedge pclk) begin
        if (do_wr) begin
            mem[wptr_q[AW-1:0]] <= wword;
        end
    end

    // Pointers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr_q <= '0;
            rptr_q <= '0;
        end else begin
            wptr_q <= wptr_d;
            rptr_q <= rptr_d;
        end
    end

    // Programming register: defaults on reset entry, then enabled write edges may overwrite it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_q <= PRG_DEFAULT;
        end else if (mr_fall) begin
            prog_q <= PRG_DEFAULT;
        end else if (mr_act && wedge && !s2_q[S_WEN]) begin
            prog_q <= s2_q[DW-1:0];
        end
    end

    // Read data register; the ninth bit depends on the parity mode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= '0;
        end else if (mr_act && redge && !s2_q[S_REN]) begin
            rdata_q <= prog_q;
        end else if (do_rd) begin
            rdata_q[7:0] <= mem[rptr_q[AW-1:0]][7:0];
            if (prog_q[PRG_PAR_EN] && prog_q[PRG_CHECK]) begin
                rdata_q[8] <= ^mem[rptr_q[AW-1:0]];
            end else begin
                rdata_q[8] <= mem[rptr_q[AW-1:0]][8];
            end
        end
    end

    // Write-side flags move only on write edges and master reset, so a read alone leaves full standing.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_q <= 1'b0;
            afull_q <= 1'b0;
            full_q <= 1'b0;
        end else if (mr_act) begin
            half_q <= 1'b0;
            afull_q <= 1'b0;
            full_q <= 1'b0;
        end else if (wedge) begin
            half_q <= cnt_d > HALF;
            afull_q <= cnt_d >= (DEPTH - {3'h0, thr});
            full_q <= cnt_d == DEPTH;
        end
    end

    // Read-side flags move only on read edges and master reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            empty_q <= 1'b1;
            aempty_q <= 1'b1;
        end else if (mr_act) begin
            empty_q <= 1'b1;
            aempty_q <= 1'b1;
        end else if (redge) begin
            empty_q <= cnt_d == '0;
            aempty_q <= cnt_d <= {3'h0, thr};
        end
    end

    // Cascade tokens: the head holds both after master reset ends; a pulse on the expansion input hands
    // over the write token first, then the read token. Relies on correct chain wiring.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wtok_q <= 1'b0;
            rtok_q <= 1'b0;
            xo_n_q <= 1'b1;
        end else if (mr_act) begin
            wtok_q <= 1'b0;
            rtok_q <= 1'b0;
            xo_n_q <= 1'b1;
        end else if (mr_rise) begin
            wtok_q <= ~s2_q[S_FL];
            rtok_q <= ~s2_q[S_FL];
            xo_n_q <= 1'b1;
        end else begin
            xo_n_q <= 1'b1;
            if (casc && do_wr && (wptr_d - rptr_d) == DEPTH) begin
                wtok_q <= 1'b0;
                xo_n_q <= 1'b0;
            end else if (casc && cin_fall && !wtok_q) begin
                wtok_q <= 1'b1;
            end
            if (casc && do_rd && !wtok_q && cnt_d == '0) begin
                rtok_q <= 1'b0;
                xo_n_q <= 1'b0;
            end else if (casc && cin_fall && wtok_q && !rtok_q) begin
                rtok_q <= 1'b1;
            end
        end
    end

    // Pin outputs; standalone, the three status pins together give the six fill states.
    assign half_full_flag = ~half_q;
    assign empty_full_flag_n = ~(empty_q | full_q);
    assign almost_flag_or_cascade_out = casc ? xo_n_q : ~(aempty_q | afull_q);
    assign read_data_out = rdata_q[7:0];
    assign ninth_output_bit = rdata_q[8];
    assign read_data_oe_n = s2_q[S_OE];

    // APB control register; cascade mode is set by software.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_cascade_q <= 1'b0;
        end else if (psel && penable && pwrite && paddr == ADDR_CTRL) begin
            ctrl_cascade_q <= pwdata[CTRL_CASCADE];
        end
    end

    // Read data is captured in the setup phase so the access phase can finish at once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (psel && !penable) begin
            prdata_q <= '0;
            case (paddr)
                ADDR_CTRL: prdata_q[CTRL_CASCADE] <= ctrl_cascade_q;
                ADDR_STATUS: begin
                    prdata_q[ST_EMPTY] <= empty_q;
                    prdata_q[ST_AEMPTY] <= aempty_q;
                    prdata_q[ST_HALF] <= half_q;
                    prdata_q[ST_AFULL] <= afull_q;
                    prdata_q[ST_FULL] <= full_q;
                    prdata_q[ST_WTOK] <= wtok_q;
                    prdata_q[ST_RTOK] <= rtok_q;
                    prdata_q[ST_CNT+PW-1:ST_CNT] <= wptr_q - rptr_q;
                end
                ADDR_PROG: prdata_q[DW-1:0] <= prog_q;
                default: prdata_q <= '0;
            endcase
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel && penable && paddr != ADDR_CTRL && paddr != ADDR_STATUS && paddr != ADDR_PROG;
endmodule : cff_fifo_port
`default_nettype wire

/* File: verilog/cff_pkg.sv */
// Purpose: Shared constants for the clocked cascadable FIFO port.
// Assumes: One system clock; all FIFO pins are sampled into that clock.
// Notes: Register offsets are byte addresses on a 32-bit APB.
`default_nettype none
package cff_pkg;
    localparam int DW = 9;                  // Word width.
    localparam int AW = 9;                  // Memory address width.
    localparam int PW = 10;                 // Pointer width, one wrap bit.
    localparam logic [PW-1:0] DEPTH = 10'h200;
    localparam logic [PW-1:0] HALF = 10'h100;
    // Programming register layout.
    localparam int PRG_PAR_EN = 8;          // Parity on.
    localparam int PRG_CHECK = 7;           // 1 check, 0 generate.
    localparam int PRG_THR_W = 7;           // Almost threshold width.
    localparam logic [DW-1:0] PRG_DEFAULT = 9'h010;
    // Pin sync vector layout.
    localparam int SW = 17;
    localparam int S_WCLK = 16;
    localparam int S_RCLK = 15;
    localparam int S_WEN = 14;
    localparam int S_REN = 13;
    localparam int S_MR = 12;
    localparam int S_FL = 11;
    localparam int S_CIN = 10;
    localparam int S_OE = 9;
    localparam logic [SW-1:0] SYNC_RST = 17'h07E00;
    // APB map.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_PROG = 8'h08;
    localparam int CTRL_CASCADE = 0;
    localparam int ST_EMPTY = 0;
    localparam int ST_AEMPTY = 1;
    localparam int ST_HALF = 2;
    localparam int ST_AFULL = 3;
    localparam int ST_FULL = 4;
    localparam int ST_WTOK = 5;
    localparam int ST_RTOK = 6;
    localparam int ST_CNT = 8;
endpackage : cff_pkg
`default_nettype wire
